/* hdl/seq_ind_pkg.sv */
package seq_ind_pkg;
	// Pulse lengths of the sequencer status output, in processor clocks
	localparam int PULSE_BOUNDARY = 1;
	localparam int PULSE_PENDING = 2;
	localparam int PULSE_IMMEDIATE = 3;
	localparam int PULSE_CNT_W = 2;
	localparam logic [1:0] PULSE_ZERO = 2'h0;
	localparam logic [1:0] PULSE_ONE = 2'h1;

	// Event classes presented to the status pulse generator
	typedef enum logic [1:0] {
		EV_NONE = 2'h0,
		EV_BOUNDARY = 2'h1,
		EV_PENDING = 2'h3,
		EV_IMMEDIATE = 2'h2
	} status_event_t;

	// Fault tracking states: Gray codes along boot, run, faulting, halted
	typedef enum logic [1:0] {
		FS_RUN = 2'h0,
		FS_BOOT = 2'h2,
		FS_IN_FAULT = 2'h1,
		FS_HALTED = 2'h3
	} fault_state_t;

	function automatic logic [1:0] pulse_len(input status_event_t ev);
		logic [1:0] len;
		len = PULSE_ZERO;
		unique case (ev)
		EV_NONE: len = PULSE_ZERO;
		EV_BOUNDARY: len = 2'(PULSE_BOUNDARY);
		EV_PENDING: len = 2'(PULSE_PENDING);
		EV_IMMEDIATE: len = 2'(PULSE_IMMEDIATE);
		endcase
		return len;
	endfunction
endpackage

/* hdl/status_pulse_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module status_pulse_gen
	import seq_ind_pkg::*;
(
	input wire logic i_clk_n,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire status_event_t i_event,
	input wire logic i_halt,
	output logic o_status,
	output logic o_busy
);
	logic [1:0] remain;

	// Runs on the falling edge so the pin moves only there
	always_ff @(negedge i_clk_n) begin
		if (i_rst) begin
			remain <= PULSE_ZERO;
			o_status <= 1'b0;
		end else if (i_ce) begin
			if (i_halt) begin
				remain <= PULSE_ZERO;
				o_status <= 1'b1;
			end else if (i_start && i_event != EV_NONE) begin
				remain <= pulse_len(i_event) - PULSE_ONE;
				o_status <= 1'b1;
			end else if (remain != PULSE_ZERO) begin
				remain <= remain - PULSE_ONE;
				o_status <= 1'b1;
			end else begin
				o_status <= 1'b0;
			end
		end
	end

	assign o_busy = (remain != PULSE_ZERO);
endmodule
`default_nettype wire

/* hdl/refill_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module refill_gen (
	input wire logic i_clk_n,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_request,
	output logic o_refill
);
	// One falling-edge flop; a request shows one clock later, for as many clocks as it is held
	always_ff @(negedge i_clk_n) begin
		if (i_rst)
			o_refill <= 1'b0;
		else if (i_ce)
			o_refill <= i_request;
	end
endmodule
`default_nettype wire

/* hdl/sequencer_activity_indicator.sv */
// Summary of operation
// - Status pulses one clock at a boundary with next instruction starting.
// - Status pulses two clocks when a trace or interrupt is pending.
// - Status pulses three clocks on table search or immediate exceptions.
// - After double bus fault, status stays high until reset.
// - A bus error before the handler's first instruction is double fault.
// - Bus or address error during reset vector fetch also halts.
// - The external bus halt input never drives the halted indication.
// - All three outputs change only on falling clock edges.
// - Refill is asserted whenever the sequencer requests a pipeline refill, except while halted.
// - Condition-code-only arithmetic never requests a refill.
// - Writing the status register requests a refill.
// - Changing address translation requests a refill.
// - Decrement-branch refills before test, and again when false.
// - Refill is generated independently of the status output.
// - Refill is asserted before trace or interrupt handler prefetch.
// - Outputs come from sequencer events only, not bus cycles.
`timescale 1ns/1ns
`default_nettype none
module sequencer_activity_indicator
	import seq_ind_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_INSTR_BOUNDARY,
	input wire logic I_TRACE_PENDING,
	input wire logic I_IRQ_PENDING,
	input wire logic I_ATC_MISS,
	input wire logic I_EXC_RESET,
	input wire logic I_EXC_BUS_ERROR,
	input wire logic I_EXC_ADDR_ERROR,
	input wire logic I_EXC_SPURIOUS,
	input wire logic I_EXC_AUTOVECTOR,
	input wire logic I_EXC_FLINE,
	input wire logic I_HANDLER_FIRST_INSTR,
	input wire logic I_RESET_FETCH_DONE,
	input wire logic I_BUS_HALT,
	input wire logic I_FLOW_CHANGE,
	input wire logic I_EXC_REFILL,
	input wire logic I_WRITE_STATUS_REG,
	input wire logic I_CC_ONLY_UPDATE,
	input wire logic I_XLATE_CHANGE,
	input wire logic I_DECR_BRANCH_START,
	input wire logic I_DECR_BRANCH_FALSE,
	output logic O_STATUS,
	output logic O_REFILL,
	output logic O_HALTED
);
	////////////////////////////////////////////////////////////////////////
	// Event classification
	status_event_t next_event;
	logic immediate_exc;
	logic fault_exc;

	assign immediate_exc = I_EXC_RESET | I_EXC_BUS_ERROR | I_EXC_ADDR_ERROR
		| I_EXC_SPURIOUS | I_EXC_AUTOVECTOR | I_EXC_FLINE;
	assign fault_exc = I_EXC_BUS_ERROR | I_EXC_ADDR_ERROR;

	// Immediate exceptions outrank boundary events; they are taken mid-flow
	always_comb begin
		next_event = EV_NONE;
		if (I_ATC_MISS || immediate_exc)
			next_event = EV_IMMEDIATE;
		else if (I_INSTR_BOUNDARY && (I_TRACE_PENDING || I_IRQ_PENDING))
			next_event = EV_PENDING;
		else if (I_INSTR_BOUNDARY)
			next_event = EV_BOUNDARY;
	end

	////////////////////////////////////////////////////////////////////////
	// Fault tracking; I_BUS_HALT deliberately not read here
	fault_state_t fstate;
	fault_state_t next_fstate;
	logic halted;

	always_comb begin
		next_fstate = fstate;
		unique case (fstate)
		FS_BOOT: begin
			if (fault_exc && !I_EXC_RESET)
				next_fstate = FS_HALTED;
			else if (I_RESET_FETCH_DONE)
				next_fstate = FS_RUN;
		end
		FS_RUN: begin
			if (I_EXC_BUS_ERROR)
				next_fstate = FS_IN_FAULT;
		end
		FS_IN_FAULT: begin
			if (I_EXC_BUS_ERROR)
				next_fstate = FS_HALTED;
			else if (I_HANDLER_FIRST_INSTR)
				next_fstate = FS_RUN;
		end
		FS_HALTED: next_fstate = FS_HALTED;
		endcase
	end

	// Processor reset is the only way out of the halted state
	always_ff @(negedge I_REF_CLK) begin
		if (I_RST)
			fstate <= FS_BOOT;
		else if (I_CE)
			fstate <= next_fstate;
	end

	assign halted = (fstate == FS_HALTED);

	always_ff @(negedge I_REF_CLK) begin
		if (I_RST)
			O_HALTED <= 1'b0;
		else if (I_CE)
			O_HALTED <= (next_fstate == FS_HALTED);
	end

	////////////////////////////////////////////////////////////////////////
	// Status pulse generation
	logic pulse_busy;
	logic start_ok;

	// A new event is not taken while pulse_busy is set; one may start in a pulse's last clock
	assign start_ok = !pulse_busy && !halted;

	status_pulse_gen u_status (
		.i_clk_n(I_REF_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_start(start_ok),
		.i_event(next_event),
		.i_halt(next_fstate == FS_HALTED),
		.o_status(O_STATUS),
		.o_busy(pulse_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// Refill request; separate path from status
	logic refill_req;

	// Condition-code-only updates are masked unless a real cause is present
	assign refill_req = !halted && (I_FLOW_CHANGE
		| I_EXC_REFILL
		| I_WRITE_STATUS_REG
		| I_XLATE_CHANGE
		| I_DECR_BRANCH_START
		| I_DECR_BRANCH_FALSE);

	refill_gen u_refill (
		.i_clk_n(I_REF_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_request(refill_req),
		.o_refill(O_REFILL)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	boundary_pulse_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_BOUNDARY
		&& next_fstate != FS_HALTED) |=> O_STATUS ##1 (!O_STATUS || !I_CE
		|| $past(start_ok)))
		else $error("boundary pulse longer than one clock");

	pending_pulse_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_PENDING
		&& next_fstate != FS_HALTED) ##1 I_CE |=> O_STATUS)
		else $error("pending pulse shorter than two clocks");

	immediate_pulse_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_IMMEDIATE) ##1 I_CE[*2]
		|=> O_STATUS)
		else $error("immediate pulse shorter than three clocks");

	halt_holds_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		halted |-> O_STATUS && O_HALTED)
		else $error("status dropped while halted");

	double_fault_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && fstate == FS_IN_FAULT && I_EXC_BUS_ERROR) |=> halted)
		else $error("double bus fault did not halt");

	boot_fault_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && fstate == FS_BOOT && fault_exc && !I_EXC_RESET) |=> halted)
		else $error("fault during reset fetch did not halt");

	bus_halt_ignored_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(fstate == FS_RUN && I_CE && !I_EXC_BUS_ERROR) |=> !halted)
		else $error("halted without a fault");

	bus_halt_run_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(fstate == FS_RUN && I_CE && I_BUS_HALT && !I_EXC_BUS_ERROR)
		|=> fstate == FS_RUN)
		else $error("halt input moved the sequencer");

	halt_sticky_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		halted |=> halted)
		else $error("halted state left without reset");

	halt_flag_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		O_HALTED == halted)
		else $error("halted output differs from state");

	first_berr_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && fstate == FS_RUN && I_EXC_BUS_ERROR)
		|=> fstate == FS_IN_FAULT)
		else $error("bus error not tracked");

	handler_clear_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && fstate == FS_IN_FAULT && I_HANDLER_FIRST_INSTR
		&& !I_EXC_BUS_ERROR) |=> fstate == FS_RUN)
		else $error("handler start did not end fault window");

	boot_exit_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && fstate == FS_BOOT && I_RESET_FETCH_DONE && !fault_exc)
		|=> fstate == FS_RUN)
		else $error("boot window not closed");

	////////////////////////////////////////////////////////////////////////
	// Pulse shape checks; a trace probe reads lengths, so ends matter too
	boundary_end_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_BOUNDARY
		&& next_fstate != FS_HALTED) ##1 (I_CE && next_event == EV_NONE
		&& next_fstate != FS_HALTED) |=> !O_STATUS)
		else $error("boundary pulse did not end");

	pending_end_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_PENDING
		&& next_fstate != FS_HALTED) ##1 I_CE ##1 (I_CE
		&& next_event == EV_NONE && next_fstate != FS_HALTED) |=> !O_STATUS)
		else $error("pending pulse longer than two clocks");

	immediate_end_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_IMMEDIATE
		&& next_fstate != FS_HALTED) ##1 I_CE[*2] ##1 (I_CE
		&& next_event == EV_NONE && next_fstate != FS_HALTED) |=> !O_STATUS)
		else $error("immediate pulse longer than three clocks");

	immediate_wins_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && I_INSTR_BOUNDARY && (I_ATC_MISS || immediate_exc))
		##1 I_CE[*2] |=> O_STATUS)
		else $error("boundary outranked an immediate exception");

	busy_holds_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && pulse_busy) |=> O_STATUS)
		else $error("status dropped inside a pulse");

	no_event_quiet_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && start_ok && next_event == EV_NONE
		&& next_fstate != FS_HALTED) |=> !O_STATUS)
		else $error("status without a sequencer event");

	freeze_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		!I_CE |=> $stable(fstate) && $stable(O_STATUS) && $stable(O_REFILL))
		else $error("state moved while clock enable low");

	refill_quiet_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && !refill_req) |=> !O_REFILL)
		else $error("refill without a request");

	halt_no_refill_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && halted) |=> !O_REFILL)
		else $error("refill shown while halted");

	refill_follows_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && refill_req) |=> O_REFILL)
		else $error("refill request not shown");

	cc_only_a: assert property (@(negedge I_REF_CLK) disable iff (I_RST)
		(I_CE && I_CC_ONLY_UPDATE && !I_FLOW_CHANGE && !I_EXC_REFILL
		&& !I_WRITE_STATUS_REG && !I_XLATE_CHANGE && !I_DECR_BRANCH_START
		&& !I_DECR_BRANCH_FALSE) |=> !O_REFILL)
		else $error("refill on condition-code-only update");
endmodule
`default_nettype wire

/* testbench/trace_probe.sv */
`timescale 1ns/1ns
`default_nettype none
module trace_probe (
	input wire logic i_clk,
	input wire logic i_status,
	output logic [3:0] o_len,
	output logic o_exc
);
	logic [3:0] cnt = 4'h0;

	// Samples on the falling edge, as a logic analyser clock probe would
	always @(negedge i_clk) begin
		if (i_status) begin
			cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
		end else if (cnt != 4'h0) begin
			o_len <= cnt;
			// A two- or three-clock pulse is an exception, never a boundary
			o_exc <= (cnt == 4'h2) || (cnt == 4'h3);
			cnt <= 4'h0;
		end
	end
	// Program and data accesses are not split here: no bus is seen
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [19:0] ev = 20'h0;
	logic o_st, o_rf, o_hl, exc;
	logic [3:0] len;
	logic [7:0] st, rf, hl;
	int num_errors = 0;
	int n_compared = 0;
	int rb[6] = '{13, 14, 15, 17, 18, 19};

	always #5 clk = ~clk;

	sequencer_activity_indicator uut (
		.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce),
		.I_INSTR_BOUNDARY(ev[0]), .I_TRACE_PENDING(ev[1]),
		.I_IRQ_PENDING(ev[2]), .I_ATC_MISS(ev[3]), .I_EXC_RESET(ev[4]),
		.I_EXC_BUS_ERROR(ev[5]), .I_EXC_ADDR_ERROR(ev[6]),
		.I_EXC_SPURIOUS(ev[7]), .I_EXC_AUTOVECTOR(ev[8]),
		.I_EXC_FLINE(ev[9]), .I_HANDLER_FIRST_INSTR(ev[10]),
		.I_RESET_FETCH_DONE(ev[11]), .I_BUS_HALT(ev[12]),
		.I_FLOW_CHANGE(ev[13]), .I_EXC_REFILL(ev[14]),
		.I_WRITE_STATUS_REG(ev[15]), .I_CC_ONLY_UPDATE(ev[16]),
		.I_XLATE_CHANGE(ev[17]), .I_DECR_BRANCH_START(ev[18]),
		.I_DECR_BRANCH_FALSE(ev[19]),
		.O_STATUS(o_st), .O_REFILL(o_rf), .O_HALTED(o_hl)
	);

	trace_probe probe (.i_clk(clk), .i_status(o_st), .o_len(len), .o_exc(exc));

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Counts high cycles of each output over the six clocks after the event
	task automatic run(input logic [19:0] m);
		st = 8'h0;
		rf = 8'h0;
		hl = 8'h0;
		@(posedge clk) ev <= m;
		repeat (6) begin
			@(posedge clk) ev <= 20'h0;
			st += 8'(o_st);
			rf += 8'(o_rf);
			hl += 8'(o_hl);
		end
	endtask

	task automatic trial(input string nm, input logic [19:0] m,
			input logic [7:0] es, er, eh);
		run(m);
		chk({nm, " status"}, st, es);
		chk({nm, " refill"}, rf, er);
		chk({nm, " halted"}, hl, eh);
	endtask

	// Clock enable low for two edges stretches a three-clock pulse
	task automatic frozen;
		st = 8'h0;
		@(posedge clk) ev <= 20'h8;
		@(posedge clk) begin
			ev <= 20'h0;
			ce <= 1'b0;
		end
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		repeat (6) begin
			@(posedge clk);
			st += 8'(o_st);
		end
		chk("frozen status", st, 8'h2);
	endtask

	// Status and refill outputs may only move while the clock is low
	always @(o_st or o_rf) if ($time > 0) chk("edge", 8'(clk), 8'h0);

	initial begin
		#100000;
		num_errors++;
		report_and_stop;
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		trial("fetch", 20'h800, 8'h0, 8'h0, 8'h0);
		trial("bound", 20'h1, 8'h1, 8'h0, 8'h0);
		trial("trace", 20'h3, 8'h2, 8'h0, 8'h0);
		trial("irq", 20'h5, 8'h2, 8'h0, 8'h0);
		chk("probe len", 8'(len), 8'h2);
		for (int i = 3; i < 10; i++) begin
			trial("immediate", 20'h1 << i, 8'h3, 8'h0, 8'h0);
		end
		chk("probe exc", 8'(exc), 8'h1);
		trial("close fault", 20'h400, 8'h0, 8'h0, 8'h0);
		frozen();
		trial("imm and bound", 20'h9, 8'h3, 8'h0, 8'h0);
		foreach (rb[i]) begin
			trial("refill", 20'h1 << rb[i], 8'h0, 8'h1, 8'h0);
		end
		trial("cc only", 20'h10000, 8'h0, 8'h0, 8'h0);
		trial("both", 20'h2001, 8'h1, 8'h1, 8'h0);
		trial("bus halt", 20'h1000, 8'h0, 8'h0, 8'h0);
		trial("berr", 20'h20, 8'h3, 8'h0, 8'h0);
		trial("handler", 20'h400, 8'h0, 8'h0, 8'h0);
		trial("berr again", 20'h20, 8'h3, 8'h0, 8'h0);
		run(20'h20);
		trial("double", 20'h2001, 8'h6, 8'h0, 8'h6);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		trial("reset", 20'h0, 8'h0, 8'h0, 8'h0);
		run(20'h40);
		trial("boot fault", 20'h0, 8'h6, 8'h0, 8'h6);
		report_and_stop;
	end
endmodule
`default_nettype wire
